// ### verilog/bst_pkg.sv
// constants, cell layout and tap state type for the boundary-scan test port
// assumes one chain of fixed length; all widths are documented values, not parameters
package bst_pkg;

  // instruction register width and codes
  localparam int IR_W = 4;
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_SAMPLE = 4'h2;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_FLOAT = 4'h9;
  localparam logic [3:0] IR_CLAMP = 4'hc;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // boundary chain layout
  localparam int BSR_LEN = 163;
  localparam int NUM_OUT = 16;
  localparam int NUM_BI = 57;
  localparam int NUM_IN = 31;
  localparam int CELL_OUT_EN = 0;
  localparam int CELL_OUT_BASE = 1;
  localparam int CELL_BI_BASE = 17;
  localparam int CELL_IN_BASE = 131;
  localparam int CELL_NETCLK = 132;
  localparam int CELL_IN_HI = 133;
  localparam int SYNC_STAGES_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // tap controller states, gray steps along the data and instruction paths
  typedef enum logic [3:0] {
    BST_TLR = 4'h0,
    BST_RTI = 4'h1,
    BST_SDR = 4'h3,
    BST_CDR = 4'h2,
    BST_SHDR = 4'h6,
    BST_E1DR = 4'h7,
    BST_PDR = 4'h5,
    BST_E2DR = 4'h4,
    BST_UDR = 4'hc,
    BST_SIR = 4'hd,
    BST_CIR = 4'hf,
    BST_SHIR = 4'he,
    BST_E1IR = 4'ha,
    BST_PIR = 4'hb,
    BST_E2IR = 4'h9,
    BST_UIR = 4'h8
  } bst_tap_state_t;

endpackage

// ### verilog/bst_sync.sv
// two-flop level synchroniser, any width
// assumes each bit is a slow level or a toggle; multi-bit words must be held stable by the source
`timescale 1ns/1ps
module bst_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule

// ### verilog/bst_tap_fsm.sv
// sixteen-state test access port controller
// assumes tms is sampled on the rising test clock; trst_n clears it at any time
`timescale 1ns/1ps
module bst_tap_fsm
  import bst_pkg::*;
(
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  output bst_tap_state_t state
);

  bst_tap_state_t state_r;
  bst_tap_state_t state_nxt;

  // next-state table stepped by tms
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BST_TLR: state_nxt = tms ? BST_TLR : BST_RTI;
      BST_RTI: state_nxt = tms ? BST_SDR : BST_RTI;
      BST_SDR: state_nxt = tms ? BST_SIR : BST_CDR;
      BST_CDR: state_nxt = tms ? BST_E1DR : BST_SHDR;
      BST_SHDR: state_nxt = tms ? BST_E1DR : BST_SHDR;
      BST_E1DR: state_nxt = tms ? BST_UDR : BST_PDR;
      BST_PDR: state_nxt = tms ? BST_E2DR : BST_PDR;
      BST_E2DR: state_nxt = tms ? BST_UDR : BST_SHDR;
      BST_UDR: state_nxt = tms ? BST_SDR : BST_RTI;
      BST_SIR: state_nxt = tms ? BST_TLR : BST_CIR;
      BST_CIR: state_nxt = tms ? BST_E1IR : BST_SHIR;
      BST_SHIR: state_nxt = tms ? BST_E1IR : BST_SHIR;
      BST_E1IR: state_nxt = tms ? BST_UIR : BST_PIR;
      BST_PIR: state_nxt = tms ? BST_E2IR : BST_PIR;
      BST_E2IR: state_nxt = tms ? BST_UIR : BST_SHIR;
      BST_UIR: state_nxt = tms ? BST_SDR : BST_RTI;
      default: state_nxt = BST_TLR;
    endcase
  end

  // controller steps on the rising test clock
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      state_r <= BST_TLR;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign state = state_r;

  // five ones on tms always reach test-logic-reset
  a_tms_reset_path: assert property (@(posedge tck) disable iff (!trst_n)
    tms [*5] |=> state_r == BST_TLR)
    else $error("tap did not reach reset after five tms ones");

  // capture-dr follows select-dr with tms low
  a_cdr_entry: assert property (@(posedge tck) disable iff (!trst_n)
    (state_r == BST_SDR && !tms) |=> state_r == BST_CDR)
    else $error("select-dr with tms low did not enter capture-dr");

endmodule

// ### verilog/bst_tap.sv
// boundary-scan test port: instruction register, decode, 163-cell chain, bypass stage
// and pin muxing toward the system side.
// assumes tck/trst_n/tms/tdi come from a board tester; system signals are on clk;
// pin levels for capture arrive asynchronously to the test clock.
//
// Behaviour
// - four-bit instruction register without parity, shifted in serially.
// - shifted instruction becomes active only in update-IR.
// - decode extest, sample, bypass, float, clamp; other codes act as bypass.
// - test logic reset forces the bypass instruction.
// - capture-IR loads the fixed pattern 0001.
// - extest places the 163-cell boundary chain between tdi and tdo.
// - extest drives pins, captures inputs, sets directions and output enables.
// - sample captures pin and control states in capture-DR without disturbing pins.
// - sample also preloads the output cells for later extest.
// - bypass places one stage between tdi and tdo.
// - bypass stage clears to zero in capture-DR.
// - clamp selects bypass while pins are driven from held chain data.
// - float instruction turns off all drivers and selects bypass.
// - float request pin sampled during system reset floats all drivers too.
// - cell 132 observes network controller clock; none on the crystal input.
// - one control cell may gate a whole group of output cells.
`timescale 1ns/1ps
module bst_tap
  import bst_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic reset_float_request_pin,
  input wire logic [NUM_OUT-1:0] sys_out_d,
  input wire logic sys_out_en,
  input wire logic [NUM_BI-1:0] sys_bi_d,
  input wire logic [NUM_BI-1:0] sys_bi_en,
  input wire logic [NUM_BI-1:0] bi_pin_in,
  input wire logic [NUM_IN-1:0] in_pin,
  input wire logic net_ctrl_clk,
  output logic [NUM_OUT-1:0] out_pin,
  output logic [NUM_OUT-1:0] out_pin_oe,
  output logic [NUM_BI-1:0] bi_pin_out,
  output logic [NUM_BI-1:0] bi_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // controller

  bst_tap_state_t state;

  bst_tap_fsm u_fsm (
    .tck(tck),
    .trst_n(trst_n),
    .tms(tms),
    .state(state)
  );

  // state decodes used throughout the test-clock side
  wire st_tlr = (state == BST_TLR);
  wire st_cir = (state == BST_CIR);
  wire st_shir = (state == BST_SHIR);
  wire st_uir = (state == BST_UIR);
  wire st_cdr = (state == BST_CDR);
  wire st_shdr = (state == BST_SHDR);
  wire st_udr = (state == BST_UDR);

  ////////////////////////////////////////////////////////////////////////////
  // instruction register

  logic [IR_W-1:0] ir_shift_r;
  logic [IR_W-1:0] ir_shift_nxt;
  logic [IR_W-1:0] ir_r;
  logic [IR_W-1:0] ir_nxt;
  logic drive_mode_r;
  logic float_mode_r;

  // capture loads the fixed pattern, shift moves lsb toward tdo
  assign ir_shift_nxt = st_cir ? IR_CAPTURE :
                        st_shir ? {tdi, ir_shift_r[IR_W-1:1]} : ir_shift_r;

  // active instruction only moves at update, reset gives bypass
  assign ir_nxt = st_tlr ? IR_BYPASS :
                  st_uir ? ir_shift_r : ir_r;

  // decode of the active code; unknown codes fall through to bypass
  wire dec_extest = (ir_r == IR_EXTEST);
  wire dec_sample = (ir_r == IR_SAMPLE);
  wire sel_bsr = dec_extest | dec_sample;
  wire sel_bypass = ~sel_bsr;

  // mode bits are decoded from the next code so they are clean flops for crossing
  wire nxt_drive = (ir_nxt == IR_EXTEST) | (ir_nxt == IR_CLAMP);
  wire nxt_float = (ir_nxt == IR_FLOAT);

  // instruction state on the rising test clock
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ir_shift_r <= IR_CAPTURE;
      ir_r <= IR_BYPASS;
      drive_mode_r <= 1'b0;
      float_mode_r <= 1'b0;
    end else begin
      ir_shift_r <= ir_shift_nxt;
      ir_r <= ir_nxt;
      drive_mode_r <= nxt_drive;
      float_mode_r <= nxt_float;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture vector: what each cell sees in capture-DR

  logic [BSR_LEN-1:0] cap_raw;
  logic [BSR_LEN-1:0] cap_sync;

  // shared enable cell and the output group it governs
  assign cap_raw[CELL_OUT_EN] = sys_out_en;
  assign cap_raw[CELL_OUT_BASE +: NUM_OUT] = sys_out_d;
  // input cells; cell 132 watches the network controller clock
  assign cap_raw[CELL_IN_BASE] = in_pin[0];
  assign cap_raw[CELL_NETCLK] = net_ctrl_clk;
  assign cap_raw[CELL_IN_HI +: (NUM_IN - 1)] = in_pin[NUM_IN-1:1];

  // each bidirectional pin is a control cell followed by its data cell
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BI; gi++) begin : g_bi_cap
      assign cap_raw[CELL_BI_BASE + 2 * gi] = sys_bi_en[gi];
      assign cap_raw[CELL_BI_BASE + 2 * gi + 1] = bi_pin_in[gi];
    end
  endgenerate

  // pins and system levels are unrelated to tck, so they settle through two flops;
  // the tester still has to align its sample to the system clock
  bst_sync #(.W(BSR_LEN)) u_cap_sync (
    .clk(tck),
    .rst(~trst_n),
    .d(cap_raw),
    .q(cap_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // boundary chain, update latches and bypass stage

  logic [BSR_LEN-1:0] bsr_shift_r;
  logic [BSR_LEN-1:0] bsr_shift_nxt;
  logic [BSR_LEN-1:0] bsr_upd_r;
  logic bypass_r;
  logic bypass_nxt;
  logic upd_tog_r;

  // chain captures or shifts only while an instruction selects it
  assign bsr_shift_nxt = (st_cdr && sel_bsr) ? cap_sync :
                         (st_shdr && sel_bsr) ? {tdi, bsr_shift_r[BSR_LEN-1:1]} : bsr_shift_r;

  // bypass stage clears at capture, then is a single shift stage
  assign bypass_nxt = (st_cdr && sel_bypass) ? 1'b0 :
                      (st_shdr && sel_bypass) ? tdi : bypass_r;

  // update latches load under extest or sample; sample thus preloads
  wire upd_load = st_udr & sel_bsr;

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      bsr_shift_r <= '0;
      bsr_upd_r <= '0;
      bypass_r <= 1'b0;
      upd_tog_r <= 1'b0;
    end else begin
      bsr_shift_r <= bsr_shift_nxt;
      bypass_r <= bypass_nxt;
      if (upd_load) begin
        bsr_upd_r <= bsr_shift_r;
        upd_tog_r <= ~upd_tog_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial output on the falling test clock

  logic tdo_r;
  logic tdo_oe_r;

  // selected stage presented half a cycle ahead of the tester's rising sample
  wire tdo_sel = st_shir ? ir_shift_r[0] :
                 sel_bsr ? bsr_shift_r[0] : bypass_r;
  wire tdo_en = st_shir | st_shdr;

  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else begin
      tdo_r <= tdo_sel;
      tdo_oe_r <= tdo_en;
    end
  end

  assign tdo = tdo_r;
  assign tdo_oe = tdo_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // crossing to the system clock: modes as levels, update data by toggle

  logic [SYNC_STAGES_W-1:0] xs_d;
  logic [SYNC_STAGES_W-1:0] xs_q;

  assign xs_d = {reset_float_request_pin, upd_tog_r, float_mode_r, drive_mode_r};

  // not cleared by system reset: the strap has to reach strap_s while reset is still held
  bst_sync #(.W(SYNC_STAGES_W)) u_sys_sync (
    .clk(clk),
    .rst(1'b0),
    .d(xs_d),
    .q(xs_q)
  );

  wire drive_s = xs_q[0];
  wire float_s = xs_q[1];
  wire tog_s = xs_q[2];
  wire strap_s = xs_q[3];

  logic tog_seen_r;
  logic strap_float_r;
  logic [BSR_LEN-1:0] pin_upd_r;

  // update latches are stable for several test clocks after the toggle,
  // far longer than the three system cycles the crossing takes
  wire upd_arrive = tog_s ^ tog_seen_r;

  // strap is caught while system reset is held and kept afterwards
  always_ff @(posedge clk) begin
    if (reset) begin
      tog_seen_r <= 1'b0;
      pin_upd_r <= '0;
      strap_float_r <= strap_s;
    end else begin
      tog_seen_r <= tog_s;
      if (upd_arrive) begin
        pin_upd_r <= bsr_upd_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers

  // float by instruction or by the reset strap wins over everything
  wire float_any = float_s | strap_float_r;

  // in extest or clamp the held chain data owns the pins
  wire [NUM_OUT-1:0] out_d_sel = drive_s ? pin_upd_r[CELL_OUT_BASE +: NUM_OUT] : sys_out_d;
  // one shared enable cell governs the whole output group
  wire out_en_sel = ~float_any & (drive_s ? pin_upd_r[CELL_OUT_EN] : sys_out_en);

  logic [NUM_BI-1:0] bi_d_sel;
  logic [NUM_BI-1:0] bi_en_sel;

  generate
    for (gi = 0; gi < NUM_BI; gi++) begin : g_bi_drv
      // control cell sets direction, data cell sets the level
      assign bi_d_sel[gi] = drive_s ? pin_upd_r[CELL_BI_BASE + 2 * gi + 1] : sys_bi_d[gi];
      assign bi_en_sel[gi] = ~float_any &
                             (drive_s ? pin_upd_r[CELL_BI_BASE + 2 * gi] : sys_bi_en[gi]);
    end
  endgenerate

  logic [NUM_OUT-1:0] out_pin_r;
  logic [NUM_OUT-1:0] out_pin_oe_r;
  logic [NUM_BI-1:0] bi_pin_out_r;
  logic [NUM_BI-1:0] bi_pin_oe_r;

  // drivers are off during system reset; sample never alters this path
  always_ff @(posedge clk) begin
    if (reset) begin
      out_pin_r <= '0;
      out_pin_oe_r <= '0;
      bi_pin_out_r <= '0;
      bi_pin_oe_r <= '0;
    end else begin
      out_pin_r <= out_d_sel;
      out_pin_oe_r <= {NUM_OUT{out_en_sel}};
      bi_pin_out_r <= bi_d_sel;
      bi_pin_oe_r <= bi_en_sel;
    end
  end

  assign out_pin = out_pin_r;
  assign out_pin_oe = out_pin_oe_r;
  assign bi_pin_out = bi_pin_out_r;
  assign bi_pin_oe = bi_pin_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks on the test-clock side

  a_ir_update_load: assert property (@(posedge tck) disable iff (!trst_n)
    st_uir |=> ir_r == $past(ir_shift_r))
    else $error("instruction not taken at update-ir");

  a_ir_hold_shift: assert property (@(posedge tck) disable iff (!trst_n)
    (st_shir || st_cir) |=> ir_r == $past(ir_r))
    else $error("instruction changed outside update-ir");

  a_ir_capture_pat: assert property (@(posedge tck) disable iff (!trst_n)
    st_cir |=> ir_shift_r == IR_CAPTURE)
    else $error("capture-ir did not load 0001");

  a_ir_reset_byp: assert property (@(posedge tck) disable iff (!trst_n)
    st_tlr |=> (ir_r == IR_BYPASS && !sel_bsr))
    else $error("reset did not select bypass");

  a_decode_other: assert property (@(posedge tck) disable iff (!trst_n)
    (ir_r != IR_EXTEST && ir_r != IR_SAMPLE) |-> !sel_bsr)
    else $error("non-chain code selected the boundary chain");

  a_bypass_zero: assert property (@(posedge tck) disable iff (!trst_n)
    (st_cdr && sel_bypass) ##1 st_shdr |-> !tdo_r)
    else $error("first bypass bit out was not zero");

  a_bsr_shift_path: assert property (@(posedge tck) disable iff (!trst_n)
    (st_shdr && sel_bsr) |=> bsr_shift_r == {$past(tdi), $past(bsr_shift_r[BSR_LEN-1:1])})
    else $error("boundary chain did not shift one place");

  // state only moves on the rise, so the enable set at the fall matches it here
  a_tdo_drive_win: assert property (@(posedge tck) disable iff (!trst_n)
    tdo_oe_r == (st_shir || st_shdr))
    else $error("tdo enable outside the shift states");

  ////////////////////////////////////////////////////////////////////////////
  // checks on the system-clock side

  a_float_off: assert property (@(posedge clk) disable iff (reset)
    float_any |=> (out_pin_oe_r == '0 && bi_pin_oe_r == '0))
    else $error("driver enabled while floating");

  a_clamp_held: assert property (@(posedge clk) disable iff (reset)
    (drive_s && !float_any) |=> out_pin_r == $past(pin_upd_r[CELL_OUT_BASE +: NUM_OUT]))
    else $error("pins not driven from held chain data");

  a_normal_path: assert property (@(posedge clk) disable iff (reset)
    (!drive_s && !float_any) |=> bi_pin_out_r == $past(sys_bi_d))
    else $error("system data disturbed outside extest and clamp");

endmodule

// ### verification/bst_tester.sv
// board tester model: drives the scan port and makes the test clock only inside scan frames
// assumes the port samples on rising tck and moves tdo on falling tck
`timescale 1ns/1ps
module bst_tester (
  output logic tck,
  output logic trst_n,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // port parked in test reset with mode-select high while the system resets
  initial begin
    tck = 1'b0;
    trst_n = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one test clock cycle of 12 ns; tdo is taken at the rise, where it has stood since the fall
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #6 tck = 1'b1;
    q = tdo;
    #6 tck = 1'b0;
  endtask

  // optional test reset pulse, then five mode-select ones and a step into idle
  task automatic tap_reset(input logic use_trst);
    logic q;
    if (use_trst) begin
      trst_n = 1'b0;
      #30 trst_n = 1'b1;
      #6;
    end
    for (int i = 0; i < 5; i++) begin
      step(1'b1, 1'b0, q);
    end
    step(1'b0, 1'b0, q);
  endtask

  // from idle: capture, shift n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [163:0] din, output logic [163:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) begin
      step(1'b1, 1'b0, q);
    end
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule

// ### verification/bst_tap_tb.sv
// self-checking bench for the boundary-scan test port
// assumes the tester model drives the scan port; system inputs move at falling clk
`timescale 1ns/1ps
module bst_tap_tb;
  import bst_pkg::*;
  logic clk, reset, tck, trst_n, tms, tdi, tdo, tdo_oe, reset_float_request_pin, sys_out_en, net_ctrl_clk;
  logic [NUM_OUT-1:0] sys_out_d, out_pin, out_pin_oe;
  logic [NUM_BI-1:0] sys_bi_d, sys_bi_en, ext_bi, bi_pin_in, bi_pin_out, bi_pin_oe;
  logic [NUM_IN-1:0] in_pin;
  logic [163:0] d, p;
  int errors, samples_checked, cycles;

  // bidirectional wire level: our driver wins where enabled, the board drives only elsewhere
  assign bi_pin_in = (bi_pin_oe & bi_pin_out) | (~bi_pin_oe & ext_bi);

  bst_tester i_tester (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo));
  bst_tap i_dut (.clk(clk), .reset(reset), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .reset_float_request_pin(reset_float_request_pin), .sys_out_d(sys_out_d),
    .sys_out_en(sys_out_en), .sys_bi_d(sys_bi_d), .sys_bi_en(sys_bi_en), .bi_pin_in(bi_pin_in),
    .in_pin(in_pin), .net_ctrl_clk(net_ctrl_clk), .out_pin(out_pin), .out_pin_oe(out_pin_oe),
    .bi_pin_out(bi_pin_out), .bi_pin_oe(bi_pin_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // a hang counts as a mismatch; the whole run needs well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      conclude();
    end
  end

  task automatic check(input logic [163:0] seen, input logic [163:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  // every instruction load also reads back the capture pattern
  task automatic load_ir(input logic [3:0] code);
    i_tester.scan(1'b1, IR_W, {160'h0, code}, d);
    check(d[3:0], 4'h1);
    check(tdo_oe, 1'b0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_strap();
    @(negedge clk);
    reset = 1'b1;
    reset_float_request_pin = 1'b1;
    wait_clk(4);
    reset = 1'b0;
    wait_clk(2);
    reset_float_request_pin = 1'b0;
    wait_clk(5);
    check({out_pin_oe, bi_pin_oe}, '0);
    reset = 1'b1;
    wait_clk(4);
    reset = 1'b0;
    wait_clk(5);
    check({out_pin_oe, bi_pin_oe, bi_pin_out}, {{16{sys_out_en}}, sys_bi_en, sys_bi_d});
    $display("test strap done");
  endtask

  // all sixteen codes: chain length seen through a one-hot marker
  task automatic t_decode();
    for (int c = 0; c < 16; c++) begin
      load_ir(c[3:0]);
      i_tester.scan(1'b0, 164, 164'h1, d);
      if (c == 0 || c == 2) begin
        check(d[163], 1'b1);
      end else begin
        check(d[1:0], 2'b10);
      end
      if (c == 9) begin
        wait_clk(10);
        check({out_pin_oe, bi_pin_oe}, '0);
      end
    end
    $display("test decode done");
  endtask

  task automatic t_sample_extest();
    logic e;
    p = '0;
    p[16:0] = {16'h9e37, 1'b1};
    for (int k = 0; k < NUM_BI; k++) begin
      p[17 + 2 * k] = k[0];
      p[18 + 2 * k] = k[1];
    end
    load_ir(IR_SAMPLE);
    i_tester.scan(1'b0, BSR_LEN, p, d);
    check({d[0], d[16:1], d[131], d[132], d[162:133]}, {sys_out_en, sys_out_d, in_pin[0], 1'b1, in_pin[30:1]});
    for (int k = 0; k < NUM_BI; k++) begin
      e = sys_bi_en[k] ? sys_bi_d[k] : ext_bi[k];
      check({d[17 + 2 * k], d[18 + 2 * k]}, {sys_bi_en[k], e});
    end
    wait_clk(10);
    check({out_pin, out_pin_oe}, {sys_out_d, 16'hffff});
    load_ir(IR_EXTEST);
    wait_clk(10);
    check({out_pin, out_pin_oe}, {p[16:1], {16{p[0]}}});
    for (int k = 0; k < NUM_BI; k++) begin
      check({bi_pin_oe[k], bi_pin_out[k]}, {p[17 + 2 * k], p[18 + 2 * k]});
    end
    // pins move on the system clock and settle before the scan starts
    in_pin = ~in_pin;
    wait_clk(5);
    i_tester.scan(1'b0, BSR_LEN, p, d);
    check({d[131], d[162:133]}, {in_pin[0], in_pin[30:1]});
    for (int k = 0; k < NUM_BI; k++) begin
      check(d[18 + 2 * k], p[17 + 2 * k] ? p[18 + 2 * k] : ext_bi[k]);
    end
    $display("test sample extest done");
  endtask

  // clamp keeps pins on held chain data and shifts through the single stage
  task automatic t_clamp();
    @(negedge clk);
    sys_out_d = ~sys_out_d;
    load_ir(IR_CLAMP);
    i_tester.scan(1'b0, 164, 164'h1, d);
    check(d[1:0], 2'b10);
    wait_clk(10);
    check({out_pin, out_pin_oe}, {p[16:1], {16{p[0]}}});
    $display("test clamp done");
  endtask

  // five mode-select ones alone must drop back to bypass and release the pins
  task automatic t_tms_reset();
    load_ir(IR_EXTEST);
    i_tester.tap_reset(1'b0);
    wait_clk(10);
    check({out_pin, out_pin_oe}, {sys_out_d, 16'hffff});
    i_tester.scan(1'b0, 164, 164'h1, d);
    check(d[1:0], 2'b10);
    $display("test tms reset done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    reset_float_request_pin = 1'b0;
    sys_out_en = 1'b1;
    sys_out_d = 16'hc35a;
    sys_bi_en = 57'h0aaaaaaaaaaaaaa;
    sys_bi_d = 57'h0f0f0f0f0f0f0f0;
    ext_bi = 57'h1c3c3c3c3c3c3c3;
    in_pin = 31'h2d3c4b5a;
    net_ctrl_clk = 1'b1;
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    i_tester.tap_reset(1'b1);
    t_strap();
    t_decode();
    t_sample_extest();
    t_clamp();
    t_tms_reset();
    conclude();
  end
endmodule
